/* File: shared/dasc_defs.svh */
// Function
// R1: tx sends start to end while enabled
// R2: rx stores messages, continuing after last
// R3: clear-enable drops tx enable at completion
// R4: tx status latched, gated by enable
// R5: tx interrupts on block lines one, three
// R6: eleven idle bits end rx message
// R7: rx interrupts on block lines two, four
// R8: load bits copy address input field
// R9: clock select picks 16x, divide sixteen
// R10: rx end address is byte address
// R11: framing error latched, write-one clears
// R12: mode field 00, 01, 10 meanings
// R13: lower two blocks fixed legacy mode
// R14: async block forms two duplex channels
// R15: each buffer is only tx or rx
// R16: buffer 512x32 host, 1Kx16 line side
// R17: status bit set per channel interrupt
// R18: status bit cleared by written one
// R19: control active only in mode 01
// R20: start, eight data lsb first, stop
// R21: sample at eight then every sixteen
// R22: buffer addresses wrap around
`ifndef DASC_DEFS_SVH
`define DASC_DEFS_SVH
`define DASC_MODE_OFS      16'h00c8
`define DASC_STAT_OFS      16'h00cc
`define DASC_CTL_OFS0      16'h0060
`define DASC_CTL_STEP      16'h0008
`define DASC_DPR_BASE      16'h4800
`define DASC_DPR_SPAN_LSB  11
`define DASC_MODE_FIXED    4'ha
`define DASC_MODE_RST      10'h000
`define DASC_MODE_ASYNC    2'h1
`define DASC_STAT_LSB      8
`define DASC_BIT_TICKS     16
`define DASC_MID_TICKS     8
`define DASC_IDLE_BITS     11
`define DASC_IDLE_TICKS    (`DASC_IDLE_BITS * `DASC_BIT_TICKS)
`define DASC_B_TXEN        0
`define DASC_B_RXEN        1
`define DASC_B_CLREN       2
`define DASC_B_TXIE        3
`define DASC_B_RXIE        4
`define DASC_B_LDRXS       5
`define DASC_B_LDTXS       6
`define DASC_B_LDTXE       7
`define DASC_B_CLKSEL      8
`define DASC_F_ADDR_LSB    9
`define DASC_F_ADDR_MSB    18
`define DASC_F_REND_LSB    19
`define DASC_B_FERR        30
`define DASC_FIFO_DEPTH    4
`endif

/* File: shared/dasc_pkg.sv */
`default_nettype none
package dasc_pkg;
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } dasc_char_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dasc_rx_state_t;
endpackage
`default_nettype wire

/* File: design/dasc_fifo.sv */
`default_nettype none
module dasc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             clr_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;

   assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];

   always_ff @(posedge clk_i) begin
      if (push) mem_r[wr_ptr_r] <= in_data_i;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i || clr_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop)  rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* File: design/dasc_block.sv */
`include "dasc_defs.svh"
`default_nettype none
module dasc_block
   import dasc_pkg::*;
(
   input  wire logic        CLK_SYS_I,
   input  wire logic        SRST_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   input  wire logic [15:0] REG_ADDR_I,
   input  wire logic [31:0] REG_WDATA_I,
   output logic      [31:0] REG_RDATA_O,
   output logic             REG_RVALID_O,
   input  wire logic        CLK_PLLB_I,
   input  wire logic        CLK_5M_I,
   output logic      [1:0]  TXD_O,
   input  wire logic [1:0]  RXD_I,
   output logic      [3:0]  IRQ_O
);
   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic [9:0]  mode_r;
   logic [3:0]  stat_r;
   logic [31:0] rdata_r;
   logic        rvalid_r;
   logic [3:0]  irq_r;

   wire [1:0] blk_mode   = mode_r[1:0];
   wire       async_on   = (blk_mode == `DASC_MODE_ASYNC);        // [R19] [R12]
   wire       hit_mode   = (REG_ADDR_I == `DASC_MODE_OFS);
   wire       hit_stat   = (REG_ADDR_I == `DASC_STAT_OFS);
   wire [15:0] dpr_off   = REG_ADDR_I - `DASC_DPR_BASE;
   wire       hit_dpr    = (REG_ADDR_I >= `DASC_DPR_BASE)
                           && (dpr_off[15:`DASC_DPR_SPAN_LSB+2] == '0);
   wire [1:0] dpr_k      = dpr_off[`DASC_DPR_SPAN_LSB+1:`DASC_DPR_SPAN_LSB];
   wire [8:0] dpr_word   = dpr_off[10:2];
   wire       wr_mode    = REG_WR_I && hit_mode;
   wire       wr_stat    = REG_WR_I && hit_stat;
   wire       wr_dpr     = REG_WR_I && hit_dpr;
   wire [9:0] addr_in    = REG_WDATA_I[`DASC_F_ADDR_MSB:`DASC_F_ADDR_LSB];

   // buffers 0,2 transmit and 1,3 receive, never shared
   logic [31:0] dpr_mem [4][512];                                  // [R16] [R15]

   logic [1:0]  hit_ctl;
   logic [1:0]  wr_ctl;
   logic [31:0] ctl_rd [2];
   logic [1:0]  tx_evt;
   logic [1:0]  rx_evt;
   logic [1:0]  rx_we;
   logic [10:0] rx_wptr [2];
   logic [7:0]  rx_wbyte [2];
   logic [1:0]  ch_txie;
   logic [1:0]  ch_rxie;

   // ----------------------------------------------------------------
   // reference clock sampling
   // ----------------------------------------------------------------
   // both 16x references are far below CLK_SYS, so edges are sampled
   logic [2:0] pllb_s_r;
   logic [2:0] c5m_s_r;
   wire        pllb_tick = pllb_s_r[1] && !pllb_s_r[2];
   wire        c5m_tick  = c5m_s_r[1] && !c5m_s_r[2];

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         pllb_s_r <= '0;
         c5m_s_r  <= '0;
      end else begin
         pllb_s_r <= {pllb_s_r[1:0], CLK_PLLB_I};
         c5m_s_r  <= {c5m_s_r[1:0], CLK_5M_I};
      end
   end

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_ch                         // [R14]
         logic        tx_en_r;
         logic        rx_en_r;
         logic        clr_en_r;
         logic        txie_r;
         logic        rxie_r;
         logic        clk_sel_r;
         logic        ferr_r;
         logic [9:0]  tx_start_r;
         logic [9:0]  tx_end_r;
         logic [9:0]  rx_start_r;
         logic        tx_pend_r;
         logic        fetch_r;
         logic [10:0] fptr_r;
         logic        busy_r;
         logic [9:0]  shift_r;
         logic [3:0]  ttick_r;
         logic [3:0]  tbit_r;
         logic        tlast_r;
         logic        done_r;
         dasc_char_t  push_d;
         dasc_char_t  pop_d;
         logic        push_rdy;
         logic        pop_vld;
         logic [1:0]  rxd_s_r;
         dasc_rx_state_t rst_r;
         logic [3:0]  rtick_r;
         logic [2:0]  rbit_r;
         logic [7:0]  rsh_r;
         logic        msg_r;
         logic [7:0]  idle_r;
         logic        rx_en_d_r;
         logic [10:0] rptr_r;
         logic [10:0] rend_r;
         logic        we_r;
         logic        ev_r;
         logic        brk_r;

         wire [15:0] ctl_ofs = `DASC_CTL_OFS0 + 16'(c) * `DASC_CTL_STEP;
         assign hit_ctl[c] = (REG_ADDR_I == ctl_ofs);
         assign wr_ctl[c]  = REG_WR_I && hit_ctl[c] && async_on;
         wire [31:0] wd    = REG_WDATA_I;
         wire tick   = clk_sel_r ? pllb_tick : c5m_tick;           // [R9]
         wire tx_go  = tx_en_r && async_on;
         wire rx_go  = rx_en_r && async_on;
         wire [10:0] tx_end_b = {tx_end_r, 1'b1};
         wire [31:0] fword    = dpr_mem[2*c][fptr_r[10:2]];
         wire start  = tx_go && tx_pend_r && !fetch_r && !busy_r && !pop_vld;
         wire pushed = fetch_r && push_rdy;
         wire popped = tx_go && !busy_r && pop_vld;
         wire bit_end = tick && (ttick_r == 4'(`DASC_BIT_TICKS - 1));
         wire ferr_set = ev_r;

         assign push_d.data = fword[8*fptr_r[1:0] +: 8];
         assign push_d.last = (fptr_r == tx_end_b);

         // control register, self-clear and load strobes
         always_ff @(posedge CLK_SYS_I) begin
            if (SRST_I) begin
               tx_en_r    <= 1'b0;
               rx_en_r    <= 1'b0;
               clr_en_r   <= 1'b0;
               txie_r     <= 1'b0;
               rxie_r     <= 1'b0;
               clk_sel_r  <= 1'b0;
               tx_start_r <= '0;
               tx_end_r   <= '0;
               rx_start_r <= '0;
               tx_pend_r  <= 1'b0;
               ferr_r     <= 1'b0;
            end else begin
               if (wr_ctl[c]) begin
                  tx_en_r   <= wd[`DASC_B_TXEN];
                  rx_en_r   <= wd[`DASC_B_RXEN];
                  clr_en_r  <= wd[`DASC_B_CLREN];
                  txie_r    <= wd[`DASC_B_TXIE];
                  rxie_r    <= wd[`DASC_B_RXIE];
                  clk_sel_r <= wd[`DASC_B_CLKSEL];
                  if (wd[`DASC_B_LDRXS]) rx_start_r <= addr_in;   // [R8]
                  if (wd[`DASC_B_LDTXS]) tx_start_r <= addr_in;   // [R8]
                  if (wd[`DASC_B_LDTXE]) tx_end_r   <= addr_in;   // [R8]
               end else if (done_r && clr_en_r) begin
                  tx_en_r <= 1'b0;                                 // [R3]
               end
               // next message carries on after the last one sent
               if (pushed && push_d.last
                   && !(wr_ctl[c] && wd[`DASC_B_LDTXS]))
                  tx_start_r <= tx_end_r + 10'h001;
               // without a fresh end address or a new tx enable nothing further goes out
               if (wr_ctl[c] && (wd[`DASC_B_LDTXE]
                   || (wd[`DASC_B_TXEN] && !tx_en_r)))
                  tx_pend_r <= 1'b1;                               // [R3]
               else if (start)
                  tx_pend_r <= 1'b0;
               // set wins over the write-one clear
               if (ferr_set)
                  ferr_r <= 1'b1;                                  // [R11]
               else if (wr_ctl[c] && wd[`DASC_B_FERR])
                  ferr_r <= 1'b0;                                  // [R11]
            end
         end

         // fetch side fills the fifo, stalled by its ready
         always_ff @(posedge CLK_SYS_I) begin
            if (SRST_I || !tx_go) begin
               fetch_r <= 1'b0;
               fptr_r  <= '0;
            end else if (start) begin
               fetch_r <= 1'b1;                                    // [R1]
               fptr_r  <= {tx_start_r, 1'b0};
            end else if (pushed) begin
               if (push_d.last) fetch_r <= 1'b0;                   // [R1]
               fptr_r <= fptr_r + 11'h001;                         // [R22]
            end
         end

         dasc_fifo #(
            .WIDTH ($bits(dasc_char_t)),
            .DEPTH (`DASC_FIFO_DEPTH)
         ) u_fifo (
            .clk_i       (CLK_SYS_I),
            .srst_i      (SRST_I),
            .clr_i       (!tx_go),
            .in_valid_i  (fetch_r),
            .in_ready_o  (push_rdy),
            .in_data_i   (push_d),
            .out_valid_o (pop_vld),
            .out_ready_i (tx_go && !busy_r),
            .out_data_o  (pop_d)
         );

         // serializer: start, eight bits lsb first, stop, idle high
         always_ff @(posedge CLK_SYS_I) begin
            if (SRST_I) begin
               busy_r  <= 1'b0;
               shift_r <= 10'h3ff;
               ttick_r <= '0;
               tbit_r  <= '0;
               tlast_r <= 1'b0;
               done_r  <= 1'b0;
            end else begin
               done_r <= 1'b0;
               if (popped) begin
                  busy_r  <= 1'b1;
                  shift_r <= {1'b1, pop_d.data, 1'b0};             // [R20]
                  tlast_r <= pop_d.last;
                  ttick_r <= '0;
                  tbit_r  <= '0;
               end else if (busy_r && tick) begin
                  ttick_r <= ttick_r + 4'h1;                       // [R9]
                  if (bit_end) begin
                     shift_r <= {1'b1, shift_r[9:1]};
                     tbit_r  <= tbit_r + 4'h1;
                     if (tbit_r == 4'h9) begin
                        busy_r <= 1'b0;
                        done_r <= tlast_r;                         // [R4]
                     end
                  end
               end
            end
         end

         // receiver
         always_ff @(posedge CLK_SYS_I) begin
            if (SRST_I) begin
               rxd_s_r   <= 2'h3;
               rst_r     <= RX_IDLE;
               rtick_r   <= '0;
               rbit_r    <= '0;
               rsh_r     <= '0;
               msg_r     <= 1'b0;
               idle_r    <= '0;
               rx_en_d_r <= 1'b0;
               rptr_r    <= '0;
               rend_r    <= '0;
               we_r      <= 1'b0;
               ev_r      <= 1'b0;
               brk_r     <= 1'b0;
            end else begin
               rxd_s_r   <= {rxd_s_r[0], RXD_I[c]};
               rx_en_d_r <= rx_go;
               we_r      <= 1'b0;
               ev_r      <= 1'b0;
               if (!rx_go) begin
                  rst_r <= RX_IDLE;
                  msg_r <= 1'b0;
                  idle_r <= '0;
               end else if (!rx_en_d_r) begin
                  rptr_r <= {rx_start_r, 1'b0};                    // [R2]
               end else if (we_r) begin
                  rend_r <= rptr_r;                                // [R10]
                  rptr_r <= rptr_r + 11'h001;                      // [R22]
               end else if (rx_evt[c]) begin
                  rptr_r <= {rend_r[10:1] + 10'h001, 1'b0};        // [R2]
               end
               if (rx_go && tick) begin
                  unique case (rst_r)
                     RX_IDLE: begin
                        rtick_r <= '0;
                        // the tail of a low stop bit is no start edge
                        if (rxd_s_r[1]) brk_r <= 1'b0;
                        if (!rxd_s_r[1] && !brk_r) begin
                           rst_r  <= RX_START;                     // [R21]
                           idle_r <= '0;
                        end else if (msg_r && rxd_s_r[1]) begin
                           idle_r <= idle_r + 8'h01;
                           if (idle_r == 8'(`DASC_IDLE_TICKS - 1)) begin
                              msg_r <= 1'b0;                       // [R6]
                              idle_r <= '0;
                           end
                        end
                     end
                     RX_START: begin
                        rtick_r <= rtick_r + 4'h1;
                        if (rtick_r == 4'(`DASC_MID_TICKS - 2)) begin
                           rtick_r <= '0;                          // [R21]
                           rbit_r  <= '0;
                           rst_r   <= rxd_s_r[1] ? RX_IDLE : RX_DATA;
                        end
                     end
                     RX_DATA: begin
                        rtick_r <= rtick_r + 4'h1;
                        if (rtick_r == 4'(`DASC_BIT_TICKS - 1)) begin
                           rsh_r  <= {rxd_s_r[1], rsh_r[7:1]};     // [R20]
                           rbit_r <= rbit_r + 3'h1;
                           if (rbit_r == 3'h7) rst_r <= RX_STOP;
                        end
                     end
                     RX_STOP: begin
                        rtick_r <= rtick_r + 4'h1;
                        if (rtick_r == 4'(`DASC_BIT_TICKS - 1)) begin
                           we_r  <= 1'b1;
                           ev_r  <= !rxd_s_r[1];                   // [R11]
                           brk_r <= !rxd_s_r[1];
                           msg_r <= 1'b1;
                           rst_r <= RX_IDLE;
                        end
                     end
                  endcase
               end
            end
         end

         assign rx_evt[c]   = rx_go && tick && (rst_r == RX_IDLE) && msg_r
                              && rxd_s_r[1]
                              && (idle_r == 8'(`DASC_IDLE_TICKS - 1));
         assign tx_evt[c]   = done_r;
         assign rx_we[c]    = we_r;
         assign rx_wptr[c]  = rptr_r;
         assign rx_wbyte[c] = rsh_r;
         assign ch_txie[c]  = txie_r;
         assign ch_rxie[c]  = rxie_r;
         assign TXD_O[c]    = shift_r[0];
         assign ctl_rd[c]   = {1'b0, ferr_r, rend_r, 10'h000, clk_sel_r, 3'h0,
                               rxie_r, txie_r, clr_en_r, rx_en_r, tx_en_r};
      end
   endgenerate

   // ----------------------------------------------------------------
   // buffer memory
   // ----------------------------------------------------------------
   // line write is placed last so it wins a same-word host write
   always_ff @(posedge CLK_SYS_I) begin
      if (wr_dpr) dpr_mem[dpr_k][dpr_word] <= REG_WDATA_I;
      for (int i = 0; i < 2; i++) begin
         if (rx_we[i])
            dpr_mem[2*i+1][rx_wptr[i][10:2]][8*rx_wptr[i][1:0] +: 8]
               <= rx_wbyte[i];                                     // [R2]
      end
   end

   // ----------------------------------------------------------------
   // mode, status, interrupt lines
   // ----------------------------------------------------------------
   wire [3:0] stat_set = {rx_evt[1], tx_evt[1], rx_evt[0], tx_evt[0]}; // [R5] [R7]
   wire [3:0] stat_clr = wr_stat ? REG_WDATA_I[`DASC_STAT_LSB +: 4] : 4'h0;
   wire [3:0] ie_mask  = {ch_rxie[1], ch_txie[1], ch_rxie[0], ch_txie[0]};

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         mode_r <= `DASC_MODE_RST;
         stat_r <= '0;
         irq_r  <= '0;
      end else begin
         if (wr_mode) mode_r <= REG_WDATA_I[13:4];                 // [R13]
         stat_r <= stat_set | (stat_r & ~stat_clr);                // [R17] [R18]
         irq_r  <= stat_r & ie_mask;                               // [R4] [R6]
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   wire [31:0] rd_mux =
      hit_mode   ? {18'h0, mode_r, `DASC_MODE_FIXED} :             // [R13]
      hit_stat   ? (32'(stat_r) << `DASC_STAT_LSB) :
      hit_ctl[0] ? (async_on ? ctl_rd[0] : 32'h0) :
      hit_ctl[1] ? (async_on ? ctl_rd[1] : 32'h0) :
      hit_dpr    ? dpr_mem[dpr_k][dpr_word] : 32'h0;

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= REG_RD_I;
         if (REG_RD_I) rdata_r <= rd_mux;
      end
   end

   assign REG_RDATA_O  = rdata_r;
   assign REG_RVALID_O = rvalid_r;
   assign IRQ_O        = irq_r;
endmodule
`default_nettype wire

/* File: test/dasc_block_sva.sv */
`default_nettype none
module dasc_block_sva (
   input wire logic        CLK_SYS_I,
   input wire logic        SRST_I,
   input wire logic        REG_WR_I,
   input wire logic        REG_RD_I,
   input wire logic [15:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic [31:0] REG_RDATA_O,
   input wire logic        REG_RVALID_O,
   input wire logic        CLK_PLLB_I,
   input wire logic        CLK_5M_I,
   input wire logic [1:0]  TXD_O,
   input wire logic [1:0]  RXD_I,
   input wire logic [3:0]  IRQ_O
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (SRST_I);
   // ----------
   // properties
   // ----------
   property p_rvalid; REG_RD_I |=> REG_RVALID_O; endproperty
   property p_rvalid_cause; REG_RVALID_O |-> $past(REG_RD_I); endproperty
   property p_rdata_hold; !$past(REG_RD_I) |-> $stable(REG_RDATA_O); endproperty
   property p_unmapped;
      REG_RD_I && REG_ADDR_I == 16'h0100 |=> REG_RDATA_O == 32'h0;
   endproperty
   property p_mode_fixed;
      REG_RD_I && REG_ADDR_I == 16'h00c8 |=> REG_RDATA_O[3:0] == 4'ha && REG_RDATA_O[31:14] == 0;
   endproperty
   property p_stat_bits;
      REG_RD_I && REG_ADDR_I == 16'h00cc |=> REG_RDATA_O[31:12] == 0 && REG_RDATA_O[7:0] == 0;
   endproperty
   // a start bit spans 16 ticks, far above eight system cycles
   property p_start_bit; $fell(TXD_O[0]) |-> !TXD_O[0] [*8]; endproperty
   property p_tx_irq; $rose(IRQ_O[0]) |-> $past(TXD_O[0], 1) && $past(TXD_O[0], 16); endproperty
   property p_rx_irq; $rose(IRQ_O[1]) |-> $past(RXD_I[0], 1) && $past(RXD_I[0], 100); endproperty
   property p_irq_clr;
      REG_WR_I && REG_ADDR_I == 16'h00cc |-> ##2 (IRQ_O & $past(REG_WDATA_I[11:8], 2)) == 4'h0;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer missing");
   a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read answer");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_mode_fixed: assert property (p_mode_fixed) else $error("fixed mode field wrong");
   a_stat_bits: assert property (p_stat_bits) else $error("foreign status bit set");
   a_start_bit: assert property (p_start_bit) else $error("start bit too short");
   a_tx_irq: assert property (p_tx_irq) else $error("tx interrupt mid frame");
   a_rx_irq: assert property (p_rx_irq) else $error("rx interrupt without idle");
   a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
   c_tx_irq: cover property ($rose(IRQ_O[2]));
   c_rx_irq: cover property ($rose(IRQ_O[3]));
   c_stat_rd: cover property (REG_RD_I && REG_ADDR_I == 16'h00cc);
endmodule
bind dasc_block dasc_block_sva dasc_block_sva_i (.CLK_SYS_I, .SRST_I, .REG_WR_I, .REG_RD_I,
   .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .CLK_PLLB_I, .CLK_5M_I,
   .TXD_O, .RXD_I, .IRQ_O);
`default_nettype wire

/* File: test/dasc_serial_peer.sv */
`default_nettype none
module dasc_serial_peer (
   input  wire logic       clk_i,
   input  wire logic [1:0] line_i,
   output logic      [1:0] line_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int         bit_cyc [2] = '{128, 320};
   logic [7:0] got [$];
   initial line_o = 2'h3;
   // start low, eight data lsb first, stop; idles high
   task automatic send(input int c, input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_i);
         #1;
         line_o[c] = (i == 10) ? 1'b1 : f[i];
         repeat (bit_cyc[c] - 1) @(posedge clk_i);
      end
   endtask
   for (genvar c = 0; c < 2; c++) begin : g_mon
      initial begin
         logic [7:0] b;
         forever begin
            @(negedge line_i[c]);
            repeat (bit_cyc[c] / 2) @(posedge clk_i);
            for (int i = 0; i < 9; i++) begin
               repeat (bit_cyc[c]) @(posedge clk_i);
               if (i < 8) b[i] = line_i[c];
            end
            // low stop poisons the byte so the bench sees it
            got.push_back(line_i[c] ? b : 8'hxx);
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/dasc_block_tb.sv */
`default_nettype none
module dasc_block_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] addr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic        rvalid;
   logic        pllb = 1'b0;
   logic        ref5 = 1'b0;
   logic [1:0]  txd;
   logic [1:0]  rxd;
   logic [3:0]  irq;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          seed = 41211;
   int          cyc = 0;
   int          ptr;
   logic [31:0] v;
   logic [7:0]  exp_b [$];
   always #5 clk = ~clk;
   always #40 pllb = ~pllb;
   always #100 ref5 = ~ref5;
   dasc_block dasc_block_i (.CLK_SYS_I(clk), .SRST_I(srst), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
      .CLK_PLLB_I(pllb), .CLK_5M_I(ref5), .TXD_O(txd), .RXD_I(rxd), .IRQ_O(irq));
   dasc_serial_peer dasc_serial_peer_i (.clk_i(clk), .line_i(txd), .line_o(rxd));
   // ------------
   // bench tasks
   // ------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      #1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a);
      @(posedge clk);
      #1;
      rd = 1'b1;
      addr = a;
      @(posedge clk);
      #1;
      rd = 1'b0;
      chk({31'h0, rvalid}, 32'h1);
      v = rdata;
   endtask
   task automatic wait_irq(input int b);
      int n;
      n = 0;
      while (irq[b] !== 1'b1 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({31'h0, irq[b]}, 32'h1);
   endtask
   function automatic logic [15:0] ctl_of(input int c);
      return 16'h0060 + 16'(c * 8);
   endfunction
   task automatic stat_clear(input int b);
      rd_reg(16'h00cc);
      chk(v, 32'h100 << b);
      wr_reg(16'h00cc, 32'h0000_0f00);
      rd_reg(16'h00cc);
      chk(v, 32'h0);
   endtask
   task automatic run_tx(input int c, input int nw);
      logic [31:0] w;
      exp_b.delete();
      dasc_serial_peer_i.got.delete();
      for (int i = 0; i < nw; i++) begin
         w = $random(seed);
         wr_reg(16'h4800 + 16'(c * 32'h1000) + 16'(i * 4), w);
         for (int k = 0; k < 4; k++) exp_b.push_back(w[8*k +: 8]);
      end
      wr_reg(ctl_of(c), 32'h0000_0040);
      wr_reg(ctl_of(c), {13'h0, 10'(2 * nw - 1), 9'h08d} | (c == 0 ? 32'h100 : 32'h0));
      wait_irq(2 * c);
      chk(32'(dasc_serial_peer_i.got.size()), 32'(exp_b.size()));
      foreach (exp_b[k]) chk({24'h0, dasc_serial_peer_i.got[k]}, {24'h0, exp_b[k]});
      rd_reg(ctl_of(c));
      chk({31'h0, v[0]}, 32'h0);
      stat_clear(2 * c);
   endtask
   task automatic run_rx(input int c, input int n, input logic bad);
      exp_b.delete();
      for (int i = 0; i < n; i++) begin
         exp_b.push_back(8'($random(seed)));
         dasc_serial_peer_i.send(c, exp_b[i], !(bad && i == n - 1));
      end
      wait_irq(2 * c + 1);
      for (int i = 0; i < n; i++) begin
         rd_reg(16'h5000 + 16'(c * 32'h1000) + 16'((ptr + i) & ~3));
         chk({24'h0, v[8*((ptr+i)%4) +: 8]}, {24'h0, exp_b[i]});
      end
      rd_reg(ctl_of(c));
      chk({21'h0, v[29:19]}, 32'(ptr + n - 1));
      chk({31'h0, v[30]}, {31'h0, bad});
      ptr = ((ptr + n - 1) / 2 + 1) * 2;
      stat_clear(2 * c + 1);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         conclude();
      end
   end
   // ----------
   // main flow
   // ----------
   initial begin
      repeat (3) @(posedge clk);
      #1;
      srst = 1'b0;
      rd_reg(16'h00c8);
      chk(v, 32'h0000_000a);
      wr_reg(16'h0060, 32'h0000_01ff);
      rd_reg(16'h0060);
      chk(v, 32'h0);
      wr_reg(16'h00c8, 32'h0000_0010);
      rd_reg(16'h00c8);
      chk(v, 32'h0000_001a);
      wr_reg(16'h0100, $random(seed));
      rd_reg(16'h0100);
      chk(v, 32'h0);
      run_tx(0, 2);
      run_tx(1, 1);
      ptr = 4;
      wr_reg(16'h0060, 32'h0000_0532);
      run_rx(0, 3, 1'b0);
      run_rx(0, 2, 1'b1);
      wr_reg(16'h0060, 32'h4000_0112);
      rd_reg(16'h0060);
      chk({31'h0, v[30]}, 32'h0);
      ptr = 0;
      wr_reg(16'h0068, 32'h0000_0032);
      run_rx(1, 1, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
